// ===== dv/vdf_formatter_tb.sv
`timescale 1ns/1ps
module vdf_formatter_tb;
	import vdf_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, rd0;
	logic [9:0]  tb_luma, tb_blue, tb_shared, s_luma, s_chroma, out_g, out_b, out_r;
	logic        blank_n, sync_n, sync_pol, cfg_a, cfg_b, src_on, single, sact, sall, gen;
	logic        u, l, red;
	logic [9:0]  vals [6] = '{10'h000, 10'h040, 10'h200, 10'h3ac, 10'h3c0, 10'h3ff};
	int          n_errors, checks_done, g0, c0;

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	vdf_video_src i_vdf_video_src (.pclk(pclk), .blank_n(blank_n), .single(single), .luma(s_luma),
		.chroma(s_chroma));
	vdf_formatter i_vdf_formatter (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.in_green_luma(src_on ? s_luma : tb_luma), .in_blue_chroma(tb_blue),
		.chroma_shared_port(src_on ? s_chroma : tb_shared), .blank_n(blank_n), .sync_n(sync_n),
		.sync_pol(sync_pol), .cfg_pin_a(cfg_a), .cfg_pin_b(cfg_b), .out_green_luma(out_g),
		.out_blue_chroma(out_b), .out_red_chroma(out_r), .sync_active(sact), .sync_all_channels(sall),
		.generic_mode(gen));

	// Chroma gain only for YCbCr reduced; halves round away from zero
	function automatic logic [9:0] sc(input logic [9:0] c);
		int d;
		d = (int'(c) - 512) * 219;
		return ((u | l) && red) ? 10'(512 + (d >= 0 ? (d + 112) / 224 : -((112 - d) / 224))) : c;
	endfunction

	function automatic logic [29:0] bl_exp();
		return {red ? CODE_BLACK : CODE_ZERO, (u | l) ? {CODE_MID, CODE_MID} : {2{red ? CODE_BLACK : CODE_ZERO}}};
	endfunction

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h got %h", nm, e, g);
		end
	endtask

	task chk_out(input string nm, input logic [29:0] e);
		chk(nm, {2'h0, e}, {2'h0, out_g, out_b, out_r});
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task cyc(input logic bl, input logic [9:0] g, input logic [9:0] b, input logic [9:0] r);
		@(posedge pclk);
		blank_n <= bl;
		tb_luma <= g;
		tb_blue <= b;
		tb_shared <= r;
		#1;
	endtask

	// Pins carry the wanted value only at the second edge after the sync edge
	task cfg_phase(input logic s, input logic a, input logic b);
		@(posedge pclk);
		sync_n <= s;
		cfg_a <= ~a;
		cfg_b <= ~b;
		@(posedge pclk);
		cfg_a <= a;
		cfg_b <= b;
		@(posedge pclk);
		cfg_a <= ~a;
		cfg_b <= ~b;
		@(posedge pclk);
		#1;
	endtask

	task set_cfg(input logic af, input logic bf, input logic ar, input logic br);
		cfg_phase(1'b0, af, bf);
		red = af ^ u;
		chk("sync flags", {30'h0, 1'b1, bf}, {30'h0, sact, sall});
		chk_out("sync codes", bl_exp());
		cfg_phase(1'b1, ar, br);
		u = ar;
		l = br;
		red = af ^ ar;
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("status", {26'h0, red, 1'b0, bf, af, ar, br}, rd);
	endtask

	task end_sim();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		#100us;
		n_errors++;
		end_sim();
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{tb_luma, tb_blue, tb_shared, blank_n, sync_pol, cfg_a, cfg_b, src_on, single} = '0;
		{u, l, red, n_errors, checks_done} = '0;
		sync_n = 1'b1;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int f = 0; f < 4; f++) begin
			for (int r = 0; r < 2; r++) begin
				set_cfg(r[0] ^ f[1], r[0], f[1], f[0]);
				cyc(1'b0, 10'h3ff, 10'h3ff, 10'h3ff);
				cyc(1'b0, 10'h3ff, 10'h3ff, 10'h3ff);
				chk_out("blank", bl_exp());
				if (f < 2) begin
					for (int i = 0; i < 7; i++) begin
						cyc(1'b1, vals[i % 6], vals[(i + 2) % 6], vals[5 - i % 6]);
						if (i > 0) chk_out("pix", {vals[i - 1], sc(vals[(i + 1) % 6]), sc(vals[6 - i])});
					end
				end else begin
					src_on <= 1'b1;
					single <= f[0];
					cyc(1'b1, 10'h0, 10'h0, 10'h0);
					for (int j = 0; j < 11; j++) begin
						cyc(1'b1, 10'h0, 10'h0, 10'h0);
						g0 = (f == 2) ? 63 + j : 65 + 2 * ((j - 3) / 2);
						c0 = (f == 2) ? 512 + 2 * ((j - 1) / 2) : 64 + 4 * ((j - 3) / 4);
						if (j >= ((f == 2) ? 1 : 3)) chk_out("demux", {10'(g0), sc(10'(c0)), sc(10'(c0 + f - 1))});
					end
					src_on <= 1'b0;
				end
				$display("test format %0d reduced %0d done", f, r);
			end
		end
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl reset", CTRL_RESET, rd);
		apb(1'b1, ADDR_CTRL, 32'h1);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl", 32'h1, rd);
		cyc(1'b1, 10'h3ff, 10'h3ff, 10'h3ff);
		cyc(1'b1, 10'h3ff, 10'h3ff, 10'h3ff);
		chk_out("soft blank", bl_exp());
		apb(1'b1, ADDR_CTRL, 32'h0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		rd0 = rd;
		apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("status read only", rd0, rd);
		apb(1'b0, 8'h08, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		$display("test register bus done");
		@(posedge pclk);
		sync_pol <= 1'b1;
		cfg_a <= 1'b0;
		cfg_b <= 1'b1;
		{u, l, red} = 3'b010;
		cyc(1'b0, 10'h3ff, 10'h3ff, 10'h3ff);
		cyc(1'b0, 10'h3ff, 10'h3ff, 10'h3ff);
		chk_out("generic blank", bl_exp());
		chk("generic pin", 32'h1, {31'h0, gen});
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("generic status", 32'h11, rd & 32'h33);
		@(posedge pclk);
		cfg_a <= 1'b1;
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("generic live pins", 32'h13, rd & 32'h33);
		$display("test generic mode done");
		end_sim();
	end
endmodule

// ===== dv/vdf_video_src.sv
`timescale 1ns/1ps
module vdf_video_src (
	input  wire logic       pclk,
	input  wire logic       blank_n,
	input  wire logic       single,
	output logic      [9:0] luma,
	output logic      [9:0] chroma
);
	logic [7:0] cnt_r;
	// Held at zero while blanked, so Cb is on the port at the release edge
	always_ff @(posedge pclk) begin
		cnt_r <= blank_n ? cnt_r + 8'h01 : 8'h00;
	end
	// Single: Cb Y Cr Y on luma; dual: Y plus Cb/Cr alternating; codes 64..767
	assign luma   = 10'h040 + {2'h0, cnt_r};
	// Unused shared port toggles so a stale sample never looks right
	assign chroma = single ? {cnt_r, 2'h3} : 10'h200 + {2'h0, cnt_r};
endmodule

// ===== hdl/vdf_cfg_sampler.sv
`timescale 1ns/1ps
module vdf_cfg_sampler (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic sync_n,
	input  wire logic generic_mode,
	input  wire logic cfg_pin_a,
	input  wire logic cfg_pin_b,
	output logic      fmt_sel_upper,
	output logic      fmt_sel_lower,
	output logic      range_mode_sel,
	output logic      all_channel_pulse_sel
);
	import vdf_pkg::*;
	logic sync_d_r;
	logic pend_r;
	logic rise_r;
	logic upper_r;
	logic lower_r;
	logic range_r;
	logic allch_r;
	wire  sync_edge = sync_n != sync_d_r;
	wire  take_fmt  = pend_r && rise_r && !generic_mode;
	wire  take_aux  = pend_r && !rise_r && !generic_mode;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_d_r <= 1'b1;
			pend_r   <= 1'b0;
			rise_r   <= 1'b0;
		end else begin
			sync_d_r <= sync_n;
			pend_r   <= sync_edge;
			rise_r   <= sync_n;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_r <= 1'b0;
			lower_r <= 1'b0;
			range_r <= 1'b0;
			allch_r <= 1'b0;
		end else begin
			if (take_fmt) begin
				upper_r <= cfg_pin_a;
				lower_r <= cfg_pin_b;
			end
			if (take_aux) begin
				range_r <= cfg_pin_a;
				allch_r <= cfg_pin_b;
			end
		end
	end

	// Generic mode bypasses the sampled format copies and forces all-channel off; range_mode_sel still comes from range_r
	assign fmt_sel_upper         = generic_mode ? cfg_pin_a : upper_r;
	assign fmt_sel_lower         = generic_mode ? cfg_pin_b : lower_r;
	assign range_mode_sel        = range_r;
	assign all_channel_pulse_sel = generic_mode ? 1'b0 : allch_r;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_take_range;
		($fell(sync_n) && !generic_mode) ##1 !generic_mode |=> range_mode_sel == $past(cfg_pin_a)
			&& allch_r == $past(cfg_pin_b);
	endproperty
	a_take_range: assert property (p_take_range) else $error("range not sampled");

	property p_fmt_second_edge;
		($rose(sync_n) && !generic_mode) ##1 !generic_mode |=> upper_r == $past(cfg_pin_a);
	endproperty
	a_fmt_second_edge: assert property (p_fmt_second_edge) else $error("format not sampled");

	property p_generic_live;
		generic_mode |-> fmt_sel_upper == cfg_pin_a && fmt_sel_lower == cfg_pin_b && !all_channel_pulse_sel;
	endproperty
	a_generic_live: assert property (p_generic_live) else $error("generic pins not live");

	c_aux_load: cover property (take_aux);
endmodule

// ===== hdl/vdf_chroma_scale.sv
`timescale 1ns/1ps
module vdf_chroma_scale (
	input  wire logic [vdf_pkg::DATA_W-1:0] code_in,
	input  wire logic                       reduced,
	output logic      [vdf_pkg::DATA_W-1:0] code_out
);
	import vdf_pkg::*;
	logic signed [10:0] dev;
	logic signed [18:0] prod;
	logic signed [18:0] biased;
	logic signed [18:0] quot;
	logic [9:0]         scaled;

	// Gain applied about midscale; no clip, result stays inside 11..1012
	assign dev    = $signed({1'b0, code_in}) - $signed({1'b0, CODE_MID});
	assign prod   = 19'(dev) * 19'(SCALE_NUM);
	assign biased = prod[18] ? prod - 19'(SCALE_HALF) : prod + 19'(SCALE_HALF);
	assign quot   = biased / 19'(SCALE_DEN);
	assign scaled = 10'(quot + 19'(CODE_MID));
	assign code_out = reduced ? scaled : code_in;
endmodule

// ===== hdl/vdf_formatter.sv
`timescale 1ns/1ps
module vdf_formatter (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [vdf_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic [vdf_pkg::DATA_W-1:0] in_green_luma,
	input  wire logic [vdf_pkg::DATA_W-1:0] in_blue_chroma,
	input  wire logic [vdf_pkg::DATA_W-1:0] chroma_shared_port,
	input  wire logic                      blank_n,
	input  wire logic                      sync_n,
	input  wire logic                      sync_pol,
	input  wire logic                      cfg_pin_a,
	input  wire logic                      cfg_pin_b,
	output logic      [vdf_pkg::DATA_W-1:0] out_green_luma,
	output logic      [vdf_pkg::DATA_W-1:0] out_blue_chroma,
	output logic      [vdf_pkg::DATA_W-1:0] out_red_chroma,
	output logic                           sync_active,
	output logic                           sync_all_channels,
	output logic                           generic_mode
);
	import vdf_pkg::*;

	logic        fmt_sel_upper;
	logic        fmt_sel_lower;
	logic        range_mode_sel;
	logic        all_channel_pulse_sel;
	logic [31:0] ctrl_r;
	logic [31:0] prdata_r;
	logic        blank_d_r;
	logic [1:0]  phase_r;
	logic [1:0]  phase_nxt;
	logic [9:0]  y_d_r;
	logic [9:0]  cb_hold_r;
	logic [9:0]  cr_hold_r;
	logic [9:0]  y0_hold_r;
	logic [9:0]  y1_hold_r;
	logic [9:0]  g_nxt;
	logic [9:0]  b_nxt;
	logic [9:0]  r_nxt;
	logic [9:0]  g_r;
	logic [9:0]  b_r;
	logic [9:0]  r_r;
	logic        upd_chroma;
	logic        upd_luma;
	logic [9:0]  b_scaled;
	logic [9:0]  r_scaled;
	vdf_fmt_t    fmt;

	// Mode decode; sync_n high with sync_pol high selects generic mode, so video mode needs sync_pol low
	assign generic_mode = sync_n && sync_pol;
	assign fmt = vdf_fmt_t'({fmt_sel_upper, fmt_sel_lower});

	vdf_cfg_sampler u_cfg (
		.pclk                  (pclk),
		.presetn               (presetn),
		.sync_n                (sync_n),
		.generic_mode          (generic_mode),
		.cfg_pin_a             (cfg_pin_a),
		.cfg_pin_b             (cfg_pin_b),
		.fmt_sel_upper         (fmt_sel_upper),
		.fmt_sel_lower         (fmt_sel_lower),
		.range_mode_sel        (range_mode_sel),
		.all_channel_pulse_sel (all_channel_pulse_sel)
	);

	// Range and blanking selection
	wire reduced     = !generic_mode && (range_mode_sel != fmt_sel_upper);
	wire is_gbr      = fmt == VDF_GBR444;
	wire is_422      = fmt_sel_upper;
	wire sync_on     = !sync_n && !generic_mode;
	// Sync carries the blank level as its base, so it wins over the blank pin
	wire force_blank = sync_on || !blank_n || ctrl_r[CTRL_SOFT_BLANK];
	wire [9:0] blank_luma   = reduced ? CODE_BLACK : CODE_ZERO;
	wire [9:0] blank_chroma = is_gbr ? blank_luma : CODE_MID;
	wire blank_rise  = blank_n && !blank_d_r;

	// Demultiplex phase: restarts on the first edge with blanking released
	always_comb begin
		phase_nxt = phase_r + 2'd1;
		if (blank_rise) begin
			phase_nxt = 2'd1;
		end else if (fmt == VDF_YCC422_DUAL) begin
			phase_nxt = {1'b0, ~phase_r[0]};
		end
	end
	wire [1:0] phase_eff = blank_rise ? 2'd0 : phase_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blank_d_r <= 1'b1;
			phase_r   <= 2'd0;
		end else begin
			blank_d_r <= blank_n;
			phase_r   <= phase_nxt;
		end
	end

	// Sample capture for the multiplexed formats
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			y_d_r     <= CODE_ZERO;
			cb_hold_r <= CODE_ZERO;
			cr_hold_r <= CODE_ZERO;
			y0_hold_r <= CODE_ZERO;
			y1_hold_r <= CODE_ZERO;
		end else begin
			y_d_r <= in_green_luma;
			if (fmt == VDF_YCC422_DUAL && phase_eff == 2'd0) begin
				cb_hold_r <= chroma_shared_port;
			end
			if (fmt == VDF_YCC422_SINGLE) begin
				case (phase_eff)
					2'd0: cb_hold_r <= in_green_luma;
					2'd1: y0_hold_r <= in_green_luma;
					2'd2: cr_hold_r <= in_green_luma;
					2'd3: y1_hold_r <= in_green_luma;
					default: cb_hold_r <= cb_hold_r;
				endcase
			end
		end
	end

	// Output selection per format
	always_comb begin
		g_nxt      = in_green_luma;
		b_nxt      = in_blue_chroma;
		r_nxt      = chroma_shared_port;
		upd_luma   = 1'b1;
		upd_chroma = 1'b1;
		case (fmt)
			VDF_GBR444, VDF_YCC444: begin
				g_nxt = in_green_luma;
			end
			VDF_YCC422_DUAL: begin
				g_nxt      = y_d_r;
				b_nxt      = cb_hold_r;
				r_nxt      = chroma_shared_port;
				upd_chroma = phase_eff == 2'd1;
			end
			VDF_YCC422_SINGLE: begin
				g_nxt      = phase_eff == 2'd3 ? y0_hold_r : y1_hold_r;
				b_nxt      = cb_hold_r;
				r_nxt      = cr_hold_r;
				upd_luma   = phase_eff[0];
				upd_chroma = phase_eff == 2'd3;
			end
			default: begin
				upd_luma = 1'b1;
			end
		endcase
	end

	vdf_chroma_scale u_scale_b (
		.code_in  (b_nxt),
		.reduced  (reduced && !is_gbr),
		.code_out (b_scaled)
	);

	vdf_chroma_scale u_scale_r (
		.code_in  (r_nxt),
		.reduced  (reduced && !is_gbr),
		.code_out (r_scaled)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			g_r <= CODE_ZERO;
			b_r <= CODE_ZERO;
			r_r <= CODE_ZERO;
		end else if (force_blank) begin
			g_r <= blank_luma;
			b_r <= blank_chroma;
			r_r <= blank_chroma;
		end else begin
			if (upd_luma) begin
				g_r <= g_nxt;
			end
			if (upd_chroma) begin
				b_r <= b_scaled;
				r_r <= r_scaled;
			end
		end
	end

	assign out_green_luma    = g_r;
	assign out_blue_chroma   = b_r;
	assign out_red_chroma    = r_r;
	assign sync_active       = sync_on;
	assign sync_all_channels = sync_on && all_channel_pulse_sel;

	// APB slave, zero wait states
	wire apb_setup  = psel && !penable;
	wire apb_access = psel && penable;
	wire hit_ctrl   = paddr == ADDR_CTRL;
	wire hit_status = paddr == ADDR_STATUS;
	wire [31:0] status_word = 32'({reduced, generic_mode, all_channel_pulse_sel,
		range_mode_sel, fmt_sel_upper, fmt_sel_lower});
	wire [31:0] rd_word = hit_ctrl ? ctrl_r : (hit_status ? status_word : 32'h0000_0000);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r   <= CTRL_RESET;
			prdata_r <= 32'h0000_0000;
		end else begin
			if (apb_setup) begin
				prdata_r <= rd_word;
			end
			if (apb_access && pwrite && hit_ctrl) begin
				ctrl_r <= 32'(pwdata[CTRL_SOFT_BLANK]);
			end
		end
	end

	assign prdata  = prdata_r;
	assign pready  = 1'b1;
	assign pslverr = apb_access && !hit_ctrl && !hit_status;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_full_rate;
		(!is_422 && !force_blank && !reduced) |=> out_green_luma == $past(in_green_luma)
			&& out_blue_chroma == $past(in_blue_chroma) && out_red_chroma == $past(chroma_shared_port);
	endproperty
	a_full_rate: assert property (p_full_rate) else $error("4:4:4 data not passed");

	property p_dual_hold;
		(fmt == VDF_YCC422_DUAL && !force_blank && !blank_rise && phase_r == 2'd0)
			|=> $stable(out_blue_chroma) && $stable(out_red_chroma);
	endproperty
	a_dual_hold: assert property (p_dual_hold) else $error("chroma updated at full rate");

	property p_restart;
		(blank_rise && is_422) |=> phase_r == 2'd1 ##1 (fmt != VDF_YCC422_DUAL || phase_r == 2'd0);
	endproperty
	a_restart: assert property (p_restart) else $error("sequence did not restart");

	property p_blank_gbr;
		(force_blank && is_gbr) |=> out_green_luma == $past(blank_luma)
			&& out_red_chroma == out_green_luma && out_blue_chroma == out_green_luma;
	endproperty
	a_blank_gbr: assert property (p_blank_gbr) else $error("wrong gbr blank code");

	property p_blank_ycc_reduced;
		(force_blank && !is_gbr && reduced) |=> out_green_luma == CODE_BLACK
			&& out_blue_chroma == CODE_MID && out_red_chroma == CODE_MID;
	endproperty
	a_blank_ycc_reduced: assert property (p_blank_ycc_reduced) else $error("wrong ycc blank code");

	property p_generic_full;
		(generic_mode && force_blank) |=> out_green_luma == CODE_ZERO;
	endproperty
	a_generic_full: assert property (p_generic_full) else $error("generic mode not full range");

	property p_luma_unscaled;
		(fmt == VDF_YCC444 && reduced && !force_blank) |=> out_green_luma == $past(in_green_luma);
	endproperty
	a_luma_unscaled: assert property (p_luma_unscaled) else $error("luma was scaled");

	property p_sync_wins;
		(sync_on && blank_n) |=> out_green_luma == $past(blank_luma);
	endproperty
	a_sync_wins: assert property (p_sync_wins) else $error("sync did not force blank level");

	property p_blank_ycc_full;
		(force_blank && !is_gbr && !reduced) |=> out_green_luma == CODE_ZERO
			&& out_blue_chroma == CODE_MID && out_red_chroma == CODE_MID;
	endproperty
	a_blank_ycc_full: assert property (p_blank_ycc_full) else $error("wrong ycc full blank code");

	property p_gbr_reduced;
		(fmt == VDF_GBR444 && reduced && !force_blank) |=> out_green_luma == $past(in_green_luma)
			&& out_blue_chroma == $past(in_blue_chroma) && out_red_chroma == $past(chroma_shared_port);
	endproperty
	a_gbr_reduced: assert property (p_gbr_reduced) else $error("gbr reduced data altered");

	property p_single_luma_hold;
		(fmt == VDF_YCC422_SINGLE && !force_blank && !blank_rise && !phase_r[0]) |=> $stable(out_green_luma);
	endproperty
	a_single_luma_hold: assert property (p_single_luma_hold) else $error("single luma updated early");

	property p_single_chroma_hold;
		(fmt == VDF_YCC422_SINGLE && !force_blank && !blank_rise && phase_r != 2'd3)
			|=> $stable(out_blue_chroma) && $stable(out_red_chroma);
	endproperty
	a_single_chroma_hold: assert property (p_single_chroma_hold) else $error("single chroma updated early");

	property p_scale_mid;
		(reduced && !is_gbr && !force_blank && upd_chroma && b_nxt == CODE_MID) |=> out_blue_chroma == CODE_MID;
	endproperty
	a_scale_mid: assert property (p_scale_mid) else $error("midscale chroma moved");

	c_single: cover property (fmt == VDF_YCC422_SINGLE && upd_chroma && !force_blank);
	c_dual: cover property (fmt == VDF_YCC422_DUAL && upd_chroma && !force_blank);
	c_reduced: cover property (reduced && !is_gbr && !force_blank);
	c_generic: cover property (generic_mode && !blank_n);
endmodule

// ===== hdl/vdf_pkg.sv
package vdf_pkg;
	localparam int          DATA_W        = 10;
	localparam int          APB_AW        = 8;
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_STATUS   = 8'h04;
	localparam int          CTRL_SOFT_BLANK = 0;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
	localparam int          ST_FMT_LOWER  = 0;
	localparam int          ST_FMT_UPPER  = 1;
	localparam int          ST_RANGE      = 2;
	localparam int          ST_ALL_CH     = 3;
	localparam int          ST_GENERIC    = 4;
	localparam int          ST_REDUCED    = 5;
	localparam logic [9:0]  CODE_ZERO     = 10'h000;
	localparam logic [9:0]  CODE_BLACK    = 10'h040;
	localparam logic [9:0]  CODE_MID      = 10'h200;
	localparam int          SCALE_NUM     = 219;
	localparam int          SCALE_DEN     = 224;
	localparam int          SCALE_HALF    = SCALE_DEN / 2;
	typedef enum logic [1:0] {VDF_GBR444, VDF_YCC444, VDF_YCC422_DUAL, VDF_YCC422_SINGLE} vdf_fmt_t;
endpackage
